// File: core/aux_boot_map.vh
// Register offsets, field positions, reset values and signature constants
// for the auxiliary boot signature scanner. Definitions only.
`ifndef AUX_BOOT_MAP_VH
`define AUX_BOOT_MAP_VH

`define ADR_W 8
`define REG_ICR 8'h00
`define REG_STATUS 8'h04
`define REG_PAGE 8'h08
`define REG_EXEC 8'h0C
`define REG_MAP 8'h10
`define REG_SIZE 8'h14

`define ICR_HALT_BIT 8
`define ICR_HALT_LANE 1
`define ICR_HALT_RST 1'b1

`define ST_BUSY_BIT 0
`define ST_FOUND_BIT 1
`define ST_FAIL_BIT 2
`define ST_WAIT_BIT 3

`define MAP_ENTRIES 16
`define MAP_RST 16'h0000

`define PAGE_BYTES 32'h00000200
`define SCAN_TOP_PAGE 32'h003FFE00
`define SCAN_LOW_PAGE 32'h00000000

`define SIG_WORDS 3'h6
`define SIG_LAST 3'h5
`define SIG_B0 8'h18
`define SIG_B1 8'h00
`define SIG_B4 8'h00
`define SIG_B5 8'h01
`define SIG_ZERO 32'h00000000

`define W_SIZE 3'h2
`define W_ZERO 3'h3
`define W_OFFS 3'h4
`define W_SUM 3'h5

`endif

// File: core/sig_block_check.v
// Combinational check of a six-longword boot signature block.
// Assumes longwords are little-endian: byte zero sits in bits 7:0 of word zero.
`include "aux_boot_map.vh"
`default_nettype none

module sig_block_check (
  input wire [31:0] w0_i,
  input wire [31:0] w1_i,
  input wire [31:0] w2_i,
  input wire [31:0] w3_i,
  input wire [31:0] w4_i,
  input wire [31:0] w5_i,
  output wire ok_o
);
  wire [7:0] b0;
  wire [7:0] b1;
  wire [7:0] b2;
  wire [7:0] b3;
  wire [7:0] b4;
  wire [7:0] b5;
  wire [7:0] byte_sum;
  wire [31:0] long_sum;
  wire hdr_ok;
  wire chk_ok;
  wire tail_ok;

  assign b0 = w0_i[7:0];
  assign b1 = w0_i[15:8];
  assign b2 = w0_i[23:16];
  assign b3 = w0_i[31:24];
  assign b4 = w1_i[7:0];
  assign b5 = w1_i[15:8];

  // Byte two has no fixed value; it only enters the checksum
  assign hdr_ok = (b0 == `SIG_B0) && (b1 == `SIG_B1); // R09 R10
  // Eight-bit sum wraps; byte three is its ones complement
  assign byte_sum = b0 + b1 + b2; // R11
  assign chk_ok = (b3 == ~byte_sum); // R11
  // Bytes six and seven are free
  assign tail_ok = (b4 == `SIG_B4) && (b5 == `SIG_B5); // R12
  // Sum of size, zero and start offset, modulo two to the 32nd
  assign long_sum = w2_i + w3_i + w4_i; // R13 R15 R16
  assign ok_o = hdr_ok && chk_ok && tail_ok && (w3_i == `SIG_ZERO) && (w5_i == long_sum); // R14 R16

endmodule // sig_block_check
`default_nettype wire

// File: core/aux_boot_signature_scanner.v
// Boot gating and boot image locator for an auxiliary processor.
// Assumes a classic Wishbone master for the registers and a same-clock
// read-only probe port onto system bus memory, where err marks no memory.
// Probe answers come from logic on clk_i, so they are read without a synchroniser.
// Functional notes
// R01 - Only boot path is the signature search
// R02 - Bootstrap held until a master permits
// R03 - Map entry valid bits cleared while waiting
// R04 - Idle while halt set, start on clear
// R05 - Master loads code before clearing halt
// R06 - Scan 512-byte pages, highest address downward
// R07 - Check first six longwords at page base
// R08 - Execute found image in place, no copy
// R09 - Byte zero must be 18 hex
// R10 - Byte one zero, byte two ignored
// R11 - Byte three inverts eight-bit byte sum
// R12 - Byte four zero, five one, others free
// R13 - Offset eight holds image size in pages
// R14 - Offset twelve must be zero
// R15 - Offset sixteen holds start byte offset
// R16 - Offset twenty sums offsets eight, twelve, sixteen
// R17 - Any readable bus memory is acceptable
// R18 - Halt bit eight, bus writable, holds halt
// R19 - Failed or unreadable page: try next lower
`include "aux_boot_map.vh"
`default_nettype none

module aux_boot_signature_scanner (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output wire mem_req_o,
  output wire [31:0] mem_adr_o,
  input wire mem_ack_i,
  input wire mem_err_i,
  input wire [31:0] mem_dat_i,
  output wire [15:0] map_valid_o,
  output wire exec_start_o,
  output wire [31:0] exec_adr_o,
  output wire boot_busy_o
);

  localparam S_INIT = 3'h0;
  localparam S_WAIT = 3'h1;
  localparam S_RD = 3'h2;
  localparam S_GAP = 3'h3;
  localparam S_CHK = 3'h4;
  localparam S_NEXT = 3'h5;
  localparam S_RUN = 3'h6;
  localparam S_FAIL = 3'h7;
  localparam [15:0] MAP_RST_V = `MAP_RST;

  function reg_hit;
    input [7:0] adr;
    input [7:0] ofs;
    begin
      reg_hit = (adr == ofs);
    end
  endfunction

  // Scan states; busy is taken from the next state so the status pin comes from a flop
  function searching;
    input [2:0] st;
    begin
      searching = (st == S_RD) || (st == S_GAP) || (st == S_CHK) || (st == S_NEXT);
    end
  endfunction

  reg [2:0] st_ff;
  reg [2:0] nxt_st;
  reg [31:0] page_ff;
  reg [31:0] nxt_page;
  reg [2:0] idx_ff;
  reg [2:0] nxt_idx;
  reg req_ff;
  reg nxt_req;
  reg [31:0] adr_ff;
  reg [31:0] nxt_adr;
  reg start_ff;
  reg nxt_start;
  reg [31:0] exec_ff;
  reg [31:0] nxt_exec;
  reg [31:0] size_ff;
  reg [31:0] nxt_size;
  reg found_ff;
  reg nxt_found;
  reg fail_ff;
  reg nxt_fail;
  reg busy_ff;
  reg nxt_busy;
  reg halt_ff;
  reg [15:0] map_ff;
  reg [31:0] sig_ff [0:5];
  reg [31:0] nxt_rdata;

  wire wb_req;
  wire wb_wr;
  wire waiting;
  wire block_ok;
  wire word_taken;
  wire icr_wr;
  wire map_wr;

  // Registered ack: one wait state, dropped the cycle after it is given
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr = wb_req && wb_we_i;
  assign waiting = (st_ff == S_INIT) || (st_ff == S_WAIT);
  assign word_taken = (st_ff == S_RD) && mem_ack_i && !mem_err_i;

  assign mem_req_o = req_ff;
  assign mem_adr_o = adr_ff;
  assign map_valid_o = map_ff;
  assign exec_start_o = start_ff;
  assign exec_adr_o = exec_ff;
  assign boot_busy_o = busy_ff;
  assign icr_wr = wb_wr && reg_hit(wb_adr_i, `REG_ICR) && wb_sel_i[`ICR_HALT_LANE];
  assign map_wr = wb_wr && reg_hit(wb_adr_i, `REG_MAP);

  sig_block_check u_check (
    .w0_i(sig_ff[0]),
    .w1_i(sig_ff[1]),
    .w2_i(sig_ff[`W_SIZE]),
    .w3_i(sig_ff[`W_ZERO]),
    .w4_i(sig_ff[`W_OFFS]),
    .w5_i(sig_ff[`W_SUM]),
    .ok_o(block_ok)
  );

  // Halt request is only ever written from the bus, so no set/clear race
  always @(posedge clk_i) begin
    if (rst_i) begin
      halt_ff <= `ICR_HALT_RST; // R02
    end else if (icr_wr) begin
      halt_ff <= wb_dat_i[`ICR_HALT_BIT]; // R18
    end
  end

  // Map entries: software may mark them valid only once the block runs;
  // while waiting the clear wins, keeping stray transfers out of local memory
  genvar gi;
  generate
    for (gi = 0; gi < `MAP_ENTRIES; gi = gi + 1) begin : g_map
      always @(posedge clk_i) begin
        if (rst_i) begin
          map_ff[gi] <= MAP_RST_V[gi];
        end else if (waiting) begin
          map_ff[gi] <= 1'b0; // R03
        end else if (map_wr && wb_sel_i[gi / 8]) begin
          map_ff[gi] <= wb_dat_i[gi];
        end
      end
    end
  endgenerate

  // Boot sequencer; the memory search is the one and only way in
  always @* begin
    nxt_st = st_ff; // R01
    nxt_page = page_ff;
    nxt_idx = idx_ff;
    nxt_req = req_ff;
    nxt_start = 1'b0;
    nxt_exec = exec_ff;
    nxt_size = size_ff;
    nxt_found = found_ff;
    nxt_fail = fail_ff;
    case (st_ff)
      S_INIT: begin
        nxt_st = S_WAIT;
      end
      S_WAIT: begin
        if (!halt_ff) begin
          nxt_st = S_RD; // R04
          nxt_page = `SCAN_TOP_PAGE; // R06
          nxt_idx = 3'h0;
          nxt_req = 1'b1;
          nxt_found = 1'b0;
          nxt_fail = 1'b0;
        end
      end
      S_RD: begin
        if (mem_err_i) begin
          nxt_req = 1'b0;
          nxt_st = S_NEXT; // R19
        end else if (mem_ack_i) begin
          nxt_req = 1'b0;
          if (idx_ff == `SIG_LAST) begin
            nxt_st = S_CHK; // R07
          end else begin
            nxt_idx = idx_ff + 3'h1;
            nxt_st = S_GAP;
          end
        end
      end
      S_GAP: begin
        nxt_req = 1'b1;
        nxt_st = S_RD;
      end
      S_CHK: begin
        if (block_ok) begin
          // Jump straight into the image where it lies, whatever memory it is
          nxt_exec = page_ff + sig_ff[`W_OFFS]; // R08 R15 R17
          nxt_size = sig_ff[`W_SIZE]; // R13
          nxt_start = 1'b1; // R08
          nxt_found = 1'b1;
          nxt_st = S_RUN;
        end else begin
          nxt_st = S_NEXT; // R19
        end
      end
      S_NEXT: begin
        if (page_ff == `SCAN_LOW_PAGE) begin
          nxt_fail = 1'b1;
          nxt_st = S_FAIL;
        end else begin
          nxt_page = page_ff - `PAGE_BYTES; // R06 R19
          nxt_idx = 3'h0;
          nxt_req = 1'b1;
          nxt_st = S_RD;
        end
      end
      S_RUN: begin
        nxt_st = S_RUN;
      end
      S_FAIL: begin
        nxt_st = S_FAIL;
      end
      default: begin
        nxt_st = S_INIT;
        nxt_req = 1'b0;
      end
    endcase
    // Setting halt again at any point parks the block and restarts the boot;
    // an outstanding probe read is abandoned, so the memory side must tolerate that
    if (halt_ff && !waiting) begin
      nxt_st = S_WAIT; // R18
      nxt_req = 1'b0;
      nxt_start = 1'b0;
    end
    nxt_adr = nxt_page + {27'h0000000, nxt_idx, 2'b00}; // R07
    // Follows every override above, so a parked block never reads busy
    nxt_busy = searching(nxt_st);
  end

  // State, probe request and the start pulse move together
  always @(posedge clk_i) begin
    if (rst_i) begin
      st_ff <= S_INIT;
      req_ff <= 1'b0;
      adr_ff <= `SCAN_TOP_PAGE;
      start_ff <= 1'b0;
      busy_ff <= 1'b0;
    end else begin
      st_ff <= nxt_st;
      req_ff <= nxt_req;
      adr_ff <= nxt_adr;
      start_ff <= nxt_start;
      busy_ff <= nxt_busy;
    end
  end

  // Scan position; page and word index stay put while parked
  always @(posedge clk_i) begin
    if (rst_i) begin
      page_ff <= `SCAN_TOP_PAGE;
      idx_ff <= 3'h0;
    end else begin
      page_ff <= nxt_page;
      idx_ff <= nxt_idx;
    end
  end

  // Results of the last search, held for software
  always @(posedge clk_i) begin
    if (rst_i) begin
      exec_ff <= `SIG_ZERO;
      size_ff <= `SIG_ZERO;
      found_ff <= 1'b0;
      fail_ff <= 1'b0;
    end else begin
      exec_ff <= nxt_exec;
      size_ff <= nxt_size;
      found_ff <= nxt_found;
      fail_ff <= nxt_fail;
    end
  end

  // Signature words land in a small buffer; only six are ever held.
  // A page that errs midway leaves stale words behind, but the check runs only after all six land
  genvar gw;
  generate
    for (gw = 0; gw < `SIG_WORDS; gw = gw + 1) begin : g_sig
      always @(posedge clk_i) begin
        if (rst_i) begin
          sig_ff[gw] <= `SIG_ZERO;
        end else if (word_taken && (idx_ff == gw)) begin
          sig_ff[gw] <= mem_dat_i; // R07
        end
      end
    end
  endgenerate

  // Register read mux; unmapped offsets read zero and still get an ack
  always @* begin
    nxt_rdata = 32'h00000000;
    if (reg_hit(wb_adr_i, `REG_ICR)) begin
      nxt_rdata[`ICR_HALT_BIT] = halt_ff;
    end else if (reg_hit(wb_adr_i, `REG_STATUS)) begin
      nxt_rdata[`ST_BUSY_BIT] = boot_busy_o;
      nxt_rdata[`ST_FOUND_BIT] = found_ff;
      nxt_rdata[`ST_FAIL_BIT] = fail_ff;
      nxt_rdata[`ST_WAIT_BIT] = waiting;
    end else if (reg_hit(wb_adr_i, `REG_PAGE)) begin
      nxt_rdata = page_ff;
    end else if (reg_hit(wb_adr_i, `REG_EXEC)) begin
      nxt_rdata = exec_ff;
    end else if (reg_hit(wb_adr_i, `REG_MAP)) begin
      nxt_rdata = {16'h0000, map_ff};
    end else if (reg_hit(wb_adr_i, `REG_SIZE)) begin
      nxt_rdata = size_ff;
    end
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && !wb_we_i) begin
        wb_dat_o <= nxt_rdata;
      end
    end
  end

endmodule // aux_boot_signature_scanner
`default_nettype wire

// File: tb/scan_mem_model.sv
// Sparse bus memory behind the probe port; err where nothing is stored.
// Assumes req and address stand until ack or err.
`default_nettype none
module scan_mem_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [31:0] adr_i,
  output logic ack_o = 1'b0,
  output logic err_o = 1'b0,
  output logic [31:0] dat_o = 32'h0
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] m [logic [31:0]];
  int slow = 0;
  int cnt = 0;
  // Idle data wanders so a stale word never passes for an answer
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    err_o <= 1'b0;
    dat_o <= ~dat_o;
    if (req_i && !ack_o && !err_o) begin
      cnt <= cnt < slow ? cnt + 1 : 0;
      if (cnt >= slow) begin
        ack_o <= m.exists(adr_i) == 1;
        err_o <= m.exists(adr_i) == 0;
        if (m.exists(adr_i) == 1)
          dat_o <= m[adr_i];
      end
    end
  end
endmodule // scan_mem_model
`default_nettype wire

// File: tb/aux_boot_signature_scanner_chk.sv
// Checker of port relations of the boot signature scanner.
// Assumes bind onto the scanner top.
`include "aux_boot_map.vh"
`default_nettype none
module aux_boot_scan_chk (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire wb_ack_o,
  input wire mem_req_o,
  input wire [31:0] mem_adr_o,
  input wire mem_ack_i,
  input wire mem_err_i,
  input wire [15:0] map_valid_o,
  input wire exec_start_o,
  input wire boot_busy_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic halt_ff;
  logic [31:0] cur_ff;
  wire wr_h = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == `REG_ICR;
  wire ok = mem_req_o && mem_ack_i && !mem_err_i && !wb_cyc_i;
  wire [31:0] low_pg = {cur_ff[31:9] - 23'h1, 9'h0};
  // Mirror of the halt bit, taken at the edge the write lands
  always_ff @(posedge clk_i) begin
    if (rst_i)
      halt_ff <= `ICR_HALT_RST;
    else if (wr_h)
      halt_ff <= wb_dat_i[`ICR_HALT_BIT];
    if (mem_req_o)
      cur_ff <= mem_adr_o;
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  a_map_clear: assert property (halt_ff [*4] |-> map_valid_o == `MAP_RST)
    else $error("map valid while waiting");
  a_no_probe: assert property (halt_ff [*3] |-> !mem_req_o && !boot_busy_o)
    else $error("probe while halted");
  a_start_top: assert property ($fell(halt_ff) |-> ##[0:3] mem_req_o && mem_adr_o == `SCAN_TOP_PAGE)
    else $error("scan not started at top");
  a_req_held: assert property (mem_req_o && !mem_ack_i && !mem_err_i && !wb_cyc_i
    |=> mem_req_o && $stable(mem_adr_o))
    else $error("probe dropped early");
  a_word_step: assert property (ok && mem_adr_o[8:0] < 9'h014
    |=> !mem_req_o ##[1:2] mem_req_o && mem_adr_o == cur_ff + 32'h4)
    else $error("bad next word");
  a_err_skip: assert property (mem_req_o && mem_err_i && mem_adr_o[31:9] != 0 && !wb_cyc_i
    |=> !mem_req_o ##[1:4] mem_req_o && mem_adr_o == low_pg)
    else $error("no skip to lower page");
  a_exec_once: assert property (exec_start_o |-> cur_ff[8:0] == 9'h014 ##1 !exec_start_o && !mem_req_o)
    else $error("bad execute pulse");
  a_ack_pulse: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bad bus ack");
  c_found: cover property (exec_start_o);
  c_err: cover property (mem_req_o && mem_err_i);
  c_restart: cover property ($fell(halt_ff));
  c_fail: cover property (mem_req_o && mem_err_i && mem_adr_o == `SCAN_LOW_PAGE);
endmodule // aux_boot_scan_chk
bind aux_boot_signature_scanner aux_boot_scan_chk chk_u (
  .clk_i(clk_i),
  .rst_i(rst_i),
  .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i),
  .wb_adr_i(wb_adr_i),
  .wb_dat_i(wb_dat_i),
  .wb_ack_o(wb_ack_o),
  .mem_req_o(mem_req_o),
  .mem_adr_o(mem_adr_o),
  .mem_ack_i(mem_ack_i),
  .mem_err_i(mem_err_i),
  .map_valid_o(map_valid_o),
  .exec_start_o(exec_start_o),
  .boot_busy_o(boot_busy_o)
);
`default_nettype wire

// File: tb/aux_boot_signature_scanner_tb.sv
// Bench: scanner against a sparse bus memory and a reference search.
// Assumes scanner, header, checker and memory model compiled first.
`include "aux_boot_map.vh"
`default_nettype none
module aux_boot_signature_scanner_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] q, ex_adr, ex_pg, ex_sz;
  logic ref_ok;
  logic [31:0] lfsr = 32'hA437;
  wire [31:0] wb_dat_o, mem_adr_o, mem_dat_i, exec_adr_o;
  wire wb_ack_o, mem_req_o, mem_ack_i, mem_err_i, exec_start_o, boot_busy_o;
  wire [15:0] map_valid_o;
  int error_cnt = 0;
  int tests_run = 0;
  always #5 clk_i = ~clk_i;
  aux_boot_signature_scanner dut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .mem_req_o(mem_req_o),
    .mem_adr_o(mem_adr_o),
    .mem_ack_i(mem_ack_i),
    .mem_err_i(mem_err_i),
    .mem_dat_i(mem_dat_i),
    .map_valid_o(map_valid_o),
    .exec_start_o(exec_start_o),
    .exec_adr_o(exec_adr_o),
    .boot_busy_o(boot_busy_o)
  );
  scan_mem_model mem (.clk_i(clk_i), .req_i(mem_req_o), .adr_i(mem_adr_o), .ack_o(mem_ack_i),
    .err_o(mem_err_i), .dat_o(mem_dat_i));
  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      error_cnt++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wrap_up();
    if (error_cnt == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, a, 4'hF, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    q = wb_dat_o;
    if (n >= 20) begin
      chk("bus ack", 32'h1, 32'h0);
      wrap_up();
    end
    {wb_cyc_i, wb_stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask
  // Kind 0 is a good block, kinds 1 to 7 each spoil one field
  task automatic put(input logic [31:0] p, input int k);
    logic [31:0] r, s, o;
    logic [7:0] b0, b1;
    r = rnd();
    s = rnd() & 32'hFF;
    o = rnd() & 32'h1FC;
    b0 = k == 1 ? 8'h19 : 8'h18;
    b1 = k == 2 ? 8'h01 : 8'h00;
    mem.m[p] = {~(b0 + b1 + r[7:0]) ^ {7'h0, k == 3}, r[7:0], b1, b0};
    mem.m[p + 4] = {r[31:16], k == 5 ? 8'h00 : 8'h01, k == 4 ? 8'h01 : 8'h00};
    mem.m[p + 8] = s;
    mem.m[p + 12] = {31'h0, k == 6};
    mem.m[p + 16] = o;
    mem.m[p + 20] = s + o + (k == 6) + (k == 7);
  endtask
  task automatic ref_find();
    logic [31:0] p;
    logic [31:0] w [6];
    ref_ok = 1'b0;
    ex_pg = `SCAN_LOW_PAGE;
    for (int i = 0; i < 8192; i++) begin
      p = `SCAN_TOP_PAGE - i * 512;
      if (mem.m.exists(p) == 0)
        continue;
      foreach (w[j])
        w[j] = mem.m[p + 4 * j];
      if (w[0][15:0] == 16'h18 && w[0][31:24] == ~(8'h18 + w[0][23:16]) && w[1][15:0] == 16'h100
          && w[3] == 32'h0 && w[5] == w[2] + w[4]) begin
        ex_pg = p;
        ref_ok = 1'b1;
        ex_sz = w[2];
        ex_adr = p + w[4];
        return;
      end
    end
  endtask
  task automatic wait_exec();
    int n;
    n = 0;
    while (exec_start_o !== 1'b1 && n < 50000) begin
      @(posedge clk_i);
      n++;
    end
    chk("found", 32'h1, {31'h0, exec_start_o});
    chk("exec adr", ex_adr, exec_adr_o);
    if (n >= 50000)
      wrap_up();
  endtask
  // Waits for a search to give up; no execute pulse may appear meanwhile
  task automatic wait_idle();
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
      if (exec_start_o !== 1'b0)
        chk("no exec", 32'h0, 32'h1);
    end while (boot_busy_o !== 1'b0 && n < 50000);
    if (n >= 50000) begin
      chk("scan end", 32'h1, 32'h0);
      wrap_up();
    end
  endtask
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b1, `REG_MAP, 32'hFFFF);
    chk("map wait", 32'h0, {16'h0, map_valid_o});
    wb(1'b0, `REG_ICR, 32'h0);
    chk("halt rst", 32'h100, q & 32'h100);
    wb(1'b0, 8'hFC, 32'h0);
    chk("unmapped", 32'h0, q);
    chk("idle req", 32'h0, {31'h0, mem_req_o});
    for (int k = 1; k < 9; k++)
      put(`SCAN_TOP_PAGE - 32'h400 * (k - 1), k % 8);
    put(`SCAN_TOP_PAGE - 32'h1E00, 0);
    ref_find();
    wb(1'b1, `REG_ICR, 32'h0);
    wait_exec();
    wb(1'b0, `REG_SIZE, 32'h0);
    chk("size", ex_sz, q);
    wb(1'b0, `REG_PAGE, 32'h0);
    chk("page", ex_pg, q);
    wb(1'b0, `REG_STATUS, 32'h0);
    chk("status", 32'h2, q & 32'hF);
    wb(1'b1, `REG_MAP, 32'hA5C3);
    chk("map run", 32'hA5C3, {16'h0, map_valid_o});
    wb(1'b1, `REG_ICR, 32'h100);
    repeat (4) @(posedge clk_i);
    chk("map halt", 32'h0, {16'h0, map_valid_o});
    put(`SCAN_TOP_PAGE - 32'h1C00, 7);
    mem.slow = 2;
    ref_find();
    wb(1'b1, `REG_ICR, 32'h0);
    repeat (40) @(posedge clk_i);
    wb(1'b0, `REG_STATUS, 32'h0);
    chk("status busy", 32'h1, q & 32'hF);
    wb(1'b1, `REG_ICR, 32'h100);
    wb(1'b1, `REG_ICR, 32'h0);
    wait_exec();
    wb(1'b1, `REG_ICR, 32'h100);
    put(`SCAN_TOP_PAGE - 32'h1E00, 3);
    mem.slow = 0;
    ref_find();
    wb(1'b1, `REG_ICR, 32'h0);
    wait_idle();
    wb(1'b0, `REG_STATUS, 32'h0);
    chk("status end", ref_ok ? 32'h2 : 32'h4, q & 32'hF);
    wb(1'b0, `REG_PAGE, 32'h0);
    chk("page end", ex_pg, q);
    wrap_up();
  end
endmodule // aux_boot_signature_scanner_tb
`default_nettype wire
